//--- core/sbt_pkg.sv
package sbt_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] SBT_IDX_CTRL_A = 4'h0;
  localparam logic [3:0] SBT_IDX_CTRL_B = 4'h1;
  localparam logic [3:0] SBT_IDX_EV     = 4'h4;
  localparam logic [3:0] SBT_IDX_INT_EN = 4'h5;
  localparam logic [3:0] SBT_IDX_FLAGS  = 4'h6;
  localparam logic [3:0] SBT_IDX_STATUS = 4'h7;
  localparam logic [3:0] SBT_IDX_DEBUG  = 4'h8;
  localparam logic [3:0] SBT_IDX_BUFFER = 4'h9;
  localparam logic [3:0] SBT_IDX_CNT_L  = 4'hA;
  localparam logic [3:0] SBT_IDX_CNT_H  = 4'hB;
  localparam logic [3:0] SBT_IDX_CMP_L  = 4'hC;
  localparam logic [3:0] SBT_IDX_CMP_H  = 4'hD;
  // control_a fields
  localparam int SBT_ENABLE_BIT   = 0;
  localparam int SBT_CLOCK_SOURCE_FIELD_LSB   = 1;
  localparam int SBT_SYNCHRONIZED_RESTART_BIT_BIT  = 4;
  localparam int SBT_RUN_IN_STANDBY_BIT_BIT = 6;
  // control_b fields
  localparam int SBT_MODE_LSB     = 0;
  localparam int SBT_OUTEN_BIT    = 4;
  localparam int SBT_INIT_BIT     = 5;
  localparam int SBT_OUTPUT_SELECT_A_BIT    = 6;
  // event_control fields
  localparam int SBT_EVENT_INPUT_ENABLE_BIT   = 0;
  localparam int SBT_EDGE_BIT     = 4;
  localparam int SBT_FILTER_BIT   = 6;
  // single-bit registers use bit 0
  localparam int SBT_FLAG_BIT     = 0;
  // writable masks and reset values
  localparam logic [7:0] SBT_MASK_CTRL_A = 8'h57;
  localparam logic [7:0] SBT_MASK_CTRL_B = 8'h77;
  localparam logic [7:0] SBT_MASK_EV     = 8'h51;
  localparam logic [7:0] SBT_MASK_BIT0   = 8'h01;
  localparam logic [7:0] SBT_RST_BYTE    = 8'h00;
  localparam logic [15:0] SBT_RST_WORD   = 16'h0000;
  // axi responses
  localparam logic [1:0] SBT_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SBT_RESP_SLVERR = 2'b10;
  // noise filter depth
  localparam int SBT_FILTER_LEN = 4;

  typedef enum logic [2:0] {
    SBT_MODE_PERIODIC = 3'h0,
    SBT_MODE_TIMEOUT  = 3'h1,
    SBT_MODE_CAPTURE_FLAG_EV  = 3'h2,
    SBT_MODE_FRQ      = 3'h3,
    SBT_MODE_PW       = 3'h4,
    SBT_MODE_FRQ_PW   = 3'h5,
    SBT_MODE_SINGLE   = 3'h6,
    SBT_MODE_PWM8     = 3'h7
  } sbt_mode_t;

  typedef enum logic [1:0] {
    SBT_PERIPHERAL_CLOCK     = 2'h0,
    SBT_PERIPHERAL_CLOCK_DIV = 2'h1,
    SBT_CLK_COMP    = 2'h2,
    SBT_CLK_RSVD    = 2'h3
  } sbt_clock_source_field_t;

  // gray-coded single-shot states
  typedef enum logic [1:0] {
    SBT_SS_IDLE = 2'b00,
    SBT_SS_RUN  = 2'b01,
    SBT_SS_HOLD = 2'b11
  } sbt_ss_t;
endpackage

//--- core/sbt_timer.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// - single-shot: output low whenever counter is not running
// - single-shot: qualifying event clears counter, counts to compare, output high
// - at compare stop, output low one prescaler tick, events ignored meanwhile
// - synchronous detection: output rises two cycles after the event
// - output_select_a select set: output rises one cycle after the event
// - edge select 1 starts on any edge, 0 on rising only
// - single-shot: enabling starts counting unless counter already holds top value
// - single-shot: status running flag reads 1 while counting
// - pwm: count zero to low byte, set at zero, clear at high byte
// - pwm: high for high-byte cycles, period low byte plus one
// - pwm: zero byte gives 0, high equal low plus one gives 1
// - other modes: output enable drives initial-level bit
// - filter passes new level after four agreeing samples
// - filter runs on system clock, adds four cycles latency
// - companion clock source counts on companion ticks
// - synchronized restart bit restarts counter with companion restart
// - every capture flag set also pulses event output one cycle
// - event input acts only while event input enable is 1
// - interrupt request while flag and its enable both set
// - halt in power-down; in standby run only with run-in-standby
// - mode field encodes eight modes, 6 single-shot, 7 pwm
// - clock source 0 peripheral, 1 half, 2 companion, 3 reserved
module sbt_timer
  import sbt_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // event channel in (asynchronous) and strobe out
  input  wire logic              event_in,
  output logic                   event_out,
  // companion timer, same clock domain
  input  wire logic              companion_timer_clock,
  input  wire logic              companion_restart,
  // system power and debug state
  input  wire logic              standby_sleep,
  input  wire logic              powerdown_sleep,
  input  wire logic              debug_halt,
  // waveform pin and interrupt
  output logic                   waveform_out,
  output logic                   irq
);

  // elaboration check: the decoder reads address bits 5:2
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W must cover the register map");
  end

  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ev_ctrl_reg;
  logic [7:0]  int_en_reg;
  logic [7:0]  dbg_reg;
  logic [7:0]  buffer_reg;
  logic        flag_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] compare_capture_value_reg;
  sbt_ss_t     ss_reg;
  sbt_ss_t     ss_next;
  logic        capture_flag_set;
  logic        wave_reg;
  logic        evout_reg;
  logic        div_reg;
  logic        en_prev_reg;
  logic        ev_s1_reg;
  logic        ev_s2_reg;
  logic [SBT_FILTER_LEN-1:0] filt_reg;
  logic        level_reg;
  logic        level_prev_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [3:0]  aw_idx_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [7:0]  rdata_reg;
  logic [1:0]  rresp_reg;

  // decoded controls
  sbt_mode_t   mode;
  sbt_clock_source_field_t clock_source_field;
  logic        enable;
  logic        run_ok;
  logic        tick;
  logic        en_rise;
  logic        qual_ev;
  logic        do_write;
  logic        wr_en;
  logic        rd_fire;
  logic [3:0]  ar_idx;
  logic        pwm_level;

  assign mode    = sbt_mode_t'(ctrl_b_reg[SBT_MODE_LSB +: 3]);
  assign clock_source_field  = sbt_clock_source_field_t'(ctrl_a_reg[SBT_CLOCK_SOURCE_FIELD_LSB +: 2]);
  assign enable  = ctrl_a_reg[SBT_ENABLE_BIT];
  assign en_rise = enable & ~en_prev_reg;
  assign ar_idx  = s_axi_araddr[5:2];

  // sleep and debug gating: the counter freezes but keeps its state
  assign run_ok = enable & ~powerdown_sleep
                & ~(standby_sleep & ~ctrl_a_reg[SBT_RUN_IN_STANDBY_BIT_BIT])
                & ~(debug_halt & ~dbg_reg[SBT_FLAG_BIT]);

  // prescaler tick select; reserved source never ticks
  always_comb begin
    case (clock_source_field)
      SBT_PERIPHERAL_CLOCK:     tick = 1'b1;
      SBT_PERIPHERAL_CLOCK_DIV: tick = div_reg;
      SBT_CLK_COMP:    tick = companion_timer_clock;
      default:         tick = 1'b0;
    endcase
  end

  // divide-by-two phase for the half-rate source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 1'b0;
    end else if (run_ok) begin
      div_reg <= ~div_reg;
    end
  end

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
    end else begin
      ev_s1_reg <= event_in;
      ev_s2_reg <= ev_s1_reg;
    end
  end

  // noise filter on the system clock, independent of the prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_reg       <= '0;
      level_reg      <= 1'b0;
      level_prev_reg <= 1'b0;
    end else begin
      filt_reg       <= {filt_reg[SBT_FILTER_LEN-2:0], ev_s2_reg};
      level_prev_reg <= level_reg;
      if (!ev_ctrl_reg[SBT_FILTER_BIT]) begin
        level_reg <= ev_s2_reg;
      end else if (&filt_reg || ~|filt_reg) begin
        level_reg <= filt_reg[SBT_FILTER_LEN-1];
      end
    end
  end

  // edge qualification by edge select and input enable
  assign qual_ev = ev_ctrl_reg[SBT_EVENT_INPUT_ENABLE_BIT]
                 & (ev_ctrl_reg[SBT_EDGE_BIT] ? (level_reg ^ level_prev_reg)
                                               : (level_reg & ~level_prev_reg));

  // enable edge detect for the start-on-enable behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= enable;
    end
  end

  // counter and single-shot sequencing
  always_comb begin
    cnt_next = cnt_reg;
    ss_next  = ss_reg;
    capture_flag_set = 1'b0;
    if (!enable) begin
      ss_next = SBT_SS_IDLE;
    end else if (run_ok) begin
      case (mode)
        SBT_MODE_SINGLE: begin
          case (ss_reg)
            SBT_SS_IDLE: begin
              if (qual_ev || (en_rise && cnt_reg != compare_capture_value_reg)) begin
                cnt_next = SBT_RST_WORD;
                ss_next  = SBT_SS_RUN;
              end
            end
            SBT_SS_RUN: begin
              if (tick && cnt_reg == compare_capture_value_reg) begin
                ss_next  = SBT_SS_HOLD;
                capture_flag_set = 1'b1;
              end else if (tick) begin
                cnt_next = cnt_reg + 16'h0001;
              end
            end
            default: begin
              if (tick) begin
                ss_next = SBT_SS_IDLE;
              end
            end
          endcase
        end
        SBT_MODE_PWM8: begin
          if (tick && cnt_reg[7:0] >= compare_capture_value_reg[7:0]) begin
            cnt_next = SBT_RST_WORD;
            capture_flag_set = 1'b1;
          end else if (tick) begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
        default: begin
          // periodic: restart at top; missed top wraps through max
          if (tick && cnt_reg == compare_capture_value_reg) begin
            cnt_next = SBT_RST_WORD;
            capture_flag_set = 1'b1;
          end else if (tick) begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      endcase
      if (ctrl_a_reg[SBT_SYNCHRONIZED_RESTART_BIT_BIT] && companion_restart) begin
        cnt_next = SBT_RST_WORD;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_reg <= SBT_SS_IDLE;
    end else begin
      ss_reg <= ss_next;
    end
  end

  // counter; a high-byte write takes the buffered low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= SBT_RST_WORD;
    end else if (wr_en && aw_idx_reg == SBT_IDX_CNT_H) begin
      cnt_reg <= {wdata_reg, buffer_reg};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_capture_value_reg <= SBT_RST_WORD;
    end else if (wr_en && aw_idx_reg == SBT_IDX_CMP_H) begin
      compare_capture_value_reg <= {wdata_reg, buffer_reg};
    end
  end

  // pwm level: the compare covers both stuck cases
  assign pwm_level = (compare_capture_value_reg[7:0] != 8'h00)
                   & (cnt_reg[7:0] < compare_capture_value_reg[15:8]);

  // waveform pin, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_reg <= 1'b0;
    end else if (!ctrl_b_reg[SBT_OUTEN_BIT]) begin
      wave_reg <= 1'b0;
    end else if (mode == SBT_MODE_SINGLE) begin
      // sync: high once the state shows run, two cycles after the event
      wave_reg <= (ss_reg == SBT_SS_RUN)
                | (ctrl_b_reg[SBT_OUTPUT_SELECT_A_BIT] && ss_reg == SBT_SS_IDLE
                   && qual_ev && run_ok);
    end else if (mode == SBT_MODE_PWM8) begin
      wave_reg <= pwm_level;
    end else begin
      wave_reg <= ctrl_b_reg[SBT_INIT_BIT];
    end
  end

  // capture flag: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg  <= 1'b0;
      evout_reg <= 1'b0;
    end else begin
      evout_reg <= capture_flag_set;
      if (capture_flag_set) begin
        flag_reg <= 1'b1;
      end else if (wr_en && aw_idx_reg == SBT_IDX_FLAGS && wdata_reg[SBT_FLAG_BIT]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  assign event_out    = evout_reg;
  assign waveform_out = wave_reg;
  assign irq          = flag_reg & int_en_reg[SBT_FLAG_BIT];

  // ---- axi4-lite slave ----
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign do_write      = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_en         = do_write & wstrb_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = {24'h00_0000, rdata_reg};
  assign s_axi_rresp   = rresp_reg;

  // address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_idx_reg  <= 4'h0;
      wdata_reg   <= SBT_RST_BYTE;
      wstrb_reg   <= 1'b0;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb_reg  <= s_axi_wstrb[0];
      end
    end
  end

  // write response; unmapped indices answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= SBT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (aw_idx_reg > SBT_IDX_CMP_H || aw_idx_reg == 4'h2 || aw_idx_reg == 4'h3)
                  ? SBT_RESP_SLVERR : SBT_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // control registers; only documented bits store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg  <= SBT_RST_BYTE;
      ctrl_b_reg  <= SBT_RST_BYTE;
      ev_ctrl_reg <= SBT_RST_BYTE;
      int_en_reg  <= SBT_RST_BYTE;
      dbg_reg     <= SBT_RST_BYTE;
    end else if (wr_en) begin
      if (aw_idx_reg == SBT_IDX_CTRL_A) begin
        ctrl_a_reg <= wdata_reg & SBT_MASK_CTRL_A;
      end else if (aw_idx_reg == SBT_IDX_CTRL_B) begin
        ctrl_b_reg <= wdata_reg & SBT_MASK_CTRL_B;
      end else if (aw_idx_reg == SBT_IDX_EV) begin
        ev_ctrl_reg <= wdata_reg & SBT_MASK_EV;
      end else if (aw_idx_reg == SBT_IDX_INT_EN) begin
        int_en_reg <= wdata_reg & SBT_MASK_BIT0;
      end else if (aw_idx_reg == SBT_IDX_DEBUG) begin
        dbg_reg <= wdata_reg & SBT_MASK_BIT0;
      end
    end
  end

  // byte buffer: low-byte writes park data, low-byte reads latch the high byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_reg <= SBT_RST_BYTE;
    end else if (wr_en && (aw_idx_reg == SBT_IDX_CNT_L || aw_idx_reg == SBT_IDX_CMP_L
                           || aw_idx_reg == SBT_IDX_BUFFER)) begin
      buffer_reg <= wdata_reg;
    end else if (rd_fire && ar_idx == SBT_IDX_CNT_L) begin
      buffer_reg <= cnt_reg[15:8];
    end else if (rd_fire && ar_idx == SBT_IDX_CMP_L) begin
      buffer_reg <= compare_capture_value_reg[15:8];
    end
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= SBT_RST_BYTE;
      rresp_reg  <= SBT_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= SBT_RESP_OKAY;
      if (ar_idx == SBT_IDX_CTRL_A) begin
        rdata_reg <= ctrl_a_reg;
      end else if (ar_idx == SBT_IDX_CTRL_B) begin
        rdata_reg <= ctrl_b_reg;
      end else if (ar_idx == SBT_IDX_EV) begin
        rdata_reg <= ev_ctrl_reg;
      end else if (ar_idx == SBT_IDX_INT_EN) begin
        rdata_reg <= int_en_reg;
      end else if (ar_idx == SBT_IDX_FLAGS) begin
        rdata_reg <= {7'h00, flag_reg};
      end else if (ar_idx == SBT_IDX_STATUS) begin
        rdata_reg <= {7'h00, ss_reg == SBT_SS_RUN};
      end else if (ar_idx == SBT_IDX_DEBUG) begin
        rdata_reg <= dbg_reg;
      end else if (ar_idx == SBT_IDX_BUFFER || ar_idx == SBT_IDX_CNT_H
                   || ar_idx == SBT_IDX_CMP_H) begin
        rdata_reg <= buffer_reg;
      end else if (ar_idx == SBT_IDX_CNT_L) begin
        rdata_reg <= cnt_reg[7:0];
      end else if (ar_idx == SBT_IDX_CMP_L) begin
        rdata_reg <= compare_capture_value_reg[7:0];
      end else begin
        rdata_reg <= SBT_RST_BYTE;
        rresp_reg <= SBT_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

//--- verification/sbt_event_src.sv
`timescale 1ns/10ps
module sbt_event_src (
  // clock
  input wire logic aclk,
  // event channel and companion timer
  output logic     event_in,
  output logic     companion_timer_clock,
  output logic     companion_restart
);
  initial begin
    event_in = 1'b0;
    companion_timer_clock = 1'b0;
    companion_restart = 1'b0;
  end
  // companion tick every second cycle, free running like a prescaled clock
  always @(posedge aclk) begin
    companion_timer_clock <= !companion_timer_clock;
  end
  // each level is held several cycles so a synchronised edge is never lost
  task automatic drive(input logic lvl);
    @(posedge aclk);
    event_in <= lvl;
    repeat (3) @(posedge aclk);
  endtask
  // one-cycle restart pulse as the companion counter wraps
  task automatic restart();
    @(posedge aclk);
    companion_restart <= 1'b1;
    @(posedge aclk);
    companion_restart <= 1'b0;
  endtask
endmodule

//--- verification/sbt_timer_monitor.sv
`timescale 1ns/10ps
module sbt_timer_monitor
  import sbt_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // event strobe and interrupt request
  input wire logic        event_out,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  // the request may only fall through a register write to flag or enable
  chk_irq_hold: assert property (irq |=> irq || s_axi_bvalid)
    else $error("interrupt request dropped without a write");
  // a pending response must block the next write, else it would be lost
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_strobe_one: assert property (event_out |=> !event_out)
    else $error("event strobe longer than one cycle");
endmodule

bind sbt_timer sbt_timer_monitor #(.ADDR_W(ADDR_W)) sbt_timer_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .event_out(event_out), .irq(irq));

//--- verification/test_sixteen_bit_capture_pulse_timer.sv
`timescale 1ns/10ps
module test_sixteen_bit_capture_pulse_timer;
  import sbt_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic event_in, event_out, companion_timer_clock, companion_restart, irq, waveform_out;
  logic standby_sleep, powerdown_sleep, debug_halt;
  logic [7:0] rh;
  int miscompares, checks_done, seed, hi;

  sbt_timer sbt_timer_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .event_in, .event_out,
    .companion_timer_clock, .companion_restart, .standby_sleep, .powerdown_sleep,
    .debug_halt, .waveform_out, .irq);
  sbt_event_src sbt_event_src_i (.aclk, .event_in, .companion_timer_clock, .companion_restart);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  // bus write: both halves offered together, each released once taken
  task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    chk("bvalid", 1, s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask

  // bus read and compare
  task automatic rchk(input logic [3:0] i, input logic [31:0] e, input logic [1:0] er);
    int k;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    chk("rvalid", 1, s_axi_rvalid);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  // one single-shot trial: count high cycles and strobes while the event is applied
  task automatic shot(input logic [7:0] cb, ev, cnt, input logic lvl, input int eh);
    int st;
    wr(SBT_IDX_CTRL_A, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CNT_L, cnt, SBT_RESP_OKAY);
    wr(SBT_IDX_CNT_H, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_B, cb, SBT_RESP_OKAY);
    wr(SBT_IDX_EV, ev, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_A, 8'h01, SBT_RESP_OKAY);
    hi = 0;
    st = 0;
    fork
      sbt_event_src_i.drive(lvl);
      repeat (30) begin
        @(posedge aclk);
        if (waveform_out === 1'b1) hi++;
        if (event_out === 1'b1) st++;
      end
    join
    chk("pulse", eh, hi);
    chk("strobe", eh > 0, st);
    chk("irq", eh > 0, irq);
    rchk(SBT_IDX_STATUS, 0, SBT_RESP_OKAY);
    rchk(SBT_IDX_FLAGS, eh > 0, SBT_RESP_OKAY);
    wr(SBT_IDX_FLAGS, 8'h01, SBT_RESP_OKAY);
    chk("irq_clear", 0, irq);
  endtask

  // pwm trial against the integer model of high cycles per period
  task automatic pwm(input logic [7:0] l, h, input logic [1:0] cs);
    int per, e;
    wr(SBT_IDX_CTRL_A, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_L, l, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_H, h, SBT_RESP_OKAY);
    wr(SBT_IDX_CNT_L, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CNT_H, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_B, 8'h17, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_A, {5'h00, cs, 1'b1}, SBT_RESP_OKAY);
    per = (l + 1) * ((cs == 2'h2) ? 2 : 1);
    e = (h == 0 || l == 0) ? 0 : ((h > l) ? l + 1 : h);
    repeat (per + 4) @(posedge aclk);
    hi = 0;
    repeat (2 * per) begin
      @(posedge aclk);
      if (waveform_out === 1'b1) hi++;
    end
    chk("pwm_high", 2 * e * per / (l + 1), hi);
  endtask

  initial begin
    #(40 * 20000);
    miscompares++;
    finish_test;
  end

  initial begin
    seed = 33271;
    miscompares = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {standby_sleep, powerdown_sleep, debug_halt} = 3'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and holes in the map
    for (int i = 0; i < 14; i++) begin
      rchk(i[3:0], 0, (i == 2 || i == 3) ? SBT_RESP_SLVERR : SBT_RESP_OKAY);
    end
    wr(4'h3, 8'h55, SBT_RESP_SLVERR);
    wr(SBT_IDX_CTRL_B, 8'hff, SBT_RESP_OKAY);
    rchk(SBT_IDX_CTRL_B, {24'h00_0000, SBT_MASK_CTRL_B}, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_L, 8'h34, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_H, 8'h12, SBT_RESP_OKAY);
    rchk(SBT_IDX_CMP_L, 32'h0000_0034, SBT_RESP_OKAY);
    rchk(SBT_IDX_CMP_H, 32'h0000_0012, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_L, 8'h03, SBT_RESP_OKAY);
    wr(SBT_IDX_CMP_H, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_INT_EN, 8'h01, SBT_RESP_OKAY);
    // single-shot table: control_b, event control, counter preset, level, width
    shot(8'h16, 8'h01, 8'h03, 1'b1, 4);
    shot(8'h16, 8'h01, 8'h03, 1'b0, 0);
    shot(8'h16, 8'h11, 8'h03, 1'b1, 4);
    shot(8'h16, 8'h11, 8'h03, 1'b0, 4);
    shot(8'h16, 8'h10, 8'h03, 1'b1, 0);
    shot(8'h16, 8'h01, 8'h00, 1'b1, 4);
    shot(8'h56, 8'h11, 8'h03, 1'b0, 5);
    shot(8'h16, 8'h41, 8'h03, 1'b1, 4);
    // pwm cases, one random high byte on the companion clock
    pwm(8'h07, 8'h03, 2'h0);
    powerdown_sleep <= 1'b1;
    repeat (2) @(posedge aclk);
    hi = 0;
    repeat (16) begin
      @(posedge aclk);
      if (waveform_out === 1'b1) hi++;
    end
    chk("frozen", 1, hi == 0 || hi == 16);
    powerdown_sleep <= 1'b0;
    pwm(8'h07, 8'h00, 2'h0);
    pwm(8'h07, 8'h08, 2'h0);
    pwm(8'hff, 8'hff, 2'h0);
    rh = $random(seed) & 8'h07;
    pwm(8'h07, rh, 2'h2);
    // other modes drive the initial level
    wr(SBT_IDX_CTRL_A, 8'h00, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_B, 8'h30, SBT_RESP_OKAY);
    wr(SBT_IDX_CTRL_A, 8'h11, SBT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("level_hi", 1, waveform_out);
    wr(SBT_IDX_CTRL_B, 8'h10, SBT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("level_lo", 0, waveform_out);
    // companion restart zeroes the counter at once; it still reads 0 next cycle
    sbt_event_src_i.restart();
    rchk(SBT_IDX_CNT_L, 0, SBT_RESP_OKAY);
    finish_test;
  end
endmodule
